// >>> shared/rxe_params.svh
// Contract
// - Bit 8 spare error flag, write-one-to-clear, resets to zero.
// - Bit 7 set when any lane buffer empties unexpectedly while running.
// - Bit 6 set when any lane buffer fills unexpectedly while running.
// - Bit 5 set when any lane loses data lock while running.
// - Bit 4 set when lane deskew exceeds one multiframe boundary.
// - Bit 3 set when sink not ready while receiver data valid.
// - Interrupt raised for each set flag enabled in error enable.
// - Reinitialisation started for each set flag enabled in reinit enable.
`ifndef RXE_PARAMS_SVH
`define RXE_PARAMS_SVH
`define RXE_LANES        4
`define RXE_OFS_STATUS   8'h60
`define RXE_OFS_IRQ_EN   8'h74
`define RXE_OFS_REINIT   8'h78
`define RXE_BIT_SPARE    8
`define RXE_BIT_EMPTY    7
`define RXE_BIT_FULL     6
`define RXE_BIT_LOCK     5
`define RXE_BIT_DESKEW   4
`define RXE_BIT_SINK     3
`define RXE_FLAG_MASK    32'h0000_01F8
`define RXE_RESET_VAL    32'h0000_0000
`define RXE_RESP_OKAY    2'h0
`define RXE_RESP_SLVERR  2'h2
`endif

// >>> shared/rxe_pkg.sv
package rxe_pkg;
    typedef struct packed {
        logic [3:0] buf_empty;
        logic [3:0] buf_full;
        logic [3:0] lock_lost;
        logic       deskew_over;
        logic       link_running;
        logic       out_valid;
        logic       sink_ready;
    } rxe_events_t;
    typedef enum logic [1:0] {
        RXE_W_IDLE = 2'b00,
        RXE_W_RESP = 2'b01
    } rxe_wstate_t;
endpackage

// >>> hdl/rxe_status.sv
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "rxe_params.svh"
module rxe_status
    import rxe_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire rxe_events_t ev,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq,
    output logic             reinit_req
);
    logic [31:0] status_r, status_nxt;
    logic [31:0] irq_en_r, irq_en_nxt;
    logic [31:0] reinit_en_r, reinit_en_nxt;
    logic [31:0] set_vec;
    logic        aw_got_r, aw_got_nxt;
    logic        w_got_r, w_got_nxt;
    logic [7:0]  aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0]  w_strb_r, w_strb_nxt;
    logic        bvalid_r, bvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    logic        irq_r, irq_nxt;
    logic        reinit_r, reinit_nxt;
    logic        wr_do;
    logic [31:0] wmask;
    logic        awready_r, awready_nxt;
    logic        wready_r, wready_nxt;
    logic        arready_r, arready_nxt;

    // Lane flags only count while the link runs; deskew is link-wide
    always_comb
    begin
        set_vec = 32'h0000_0000;
        set_vec[`RXE_BIT_EMPTY] = ev.link_running & (|ev.buf_empty);
        set_vec[`RXE_BIT_FULL] = ev.link_running & (|ev.buf_full);
        set_vec[`RXE_BIT_LOCK] = ev.link_running & (|ev.lock_lost);
        set_vec[`RXE_BIT_DESKEW] = ev.deskew_over;
        set_vec[`RXE_BIT_SINK] = ev.out_valid & ~ev.sink_ready;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_lane
            assign wmask[gi*8 +: 8] = {8{w_strb_r[gi]}};
        end
    endgenerate

    assign wr_do = aw_got_r & w_got_r & ~bvalid_r;

    always_comb
    begin
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        status_nxt = status_r;
        irq_en_nxt = irq_en_r;
        reinit_en_nxt = reinit_en_r;
        if (s_axi_awvalid && !aw_got_r)
        begin
            aw_got_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_r)
        begin
            w_got_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (wr_do)
        begin
            bvalid_nxt = 1'b1;
            bresp_nxt = `RXE_RESP_OKAY;
            case (aw_addr_r)
                `RXE_OFS_STATUS:
                    // Spare bit 8 included; reserved bits untouched
                    status_nxt = status_r
                        & ~(w_data_r & wmask & `RXE_FLAG_MASK);
                `RXE_OFS_IRQ_EN:
                    irq_en_nxt = (irq_en_r & ~wmask)
                        | (w_data_r & wmask & `RXE_FLAG_MASK);
                `RXE_OFS_REINIT:
                    reinit_en_nxt = (reinit_en_r & ~wmask)
                        | (w_data_r & wmask & `RXE_FLAG_MASK);
                default:
                    bresp_nxt = `RXE_RESP_SLVERR;
            endcase
        end
        if (bvalid_r && s_axi_bready)
        begin
            bvalid_nxt = 1'b0;
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
        end
        // Set wins over a same-cycle clear
        status_nxt = status_nxt | set_vec;
        // Ready held low after capture until the response is accepted
        awready_nxt = ~aw_got_nxt;
        wready_nxt = ~w_got_nxt;
    end

    always_comb
    begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_arvalid && !rvalid_r)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `RXE_RESP_OKAY;
            case (s_axi_araddr)
                `RXE_OFS_STATUS: rdata_nxt = status_r;
                `RXE_OFS_IRQ_EN: rdata_nxt = irq_en_r;
                `RXE_OFS_REINIT: rdata_nxt = reinit_en_r;
                default:
                begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = `RXE_RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_nxt = 1'b0;
        end
        arready_nxt = ~rvalid_nxt;
    end

    always_comb
    begin
        irq_nxt = |(status_r & irq_en_r);
        reinit_nxt = |(status_r & reinit_en_r);
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            status_r <= `RXE_RESET_VAL;
            irq_en_r <= `RXE_RESET_VAL;
            reinit_en_r <= `RXE_RESET_VAL;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'h0;
            irq_r <= 1'b0;
            reinit_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            arready_r <= 1'b1;
        end
        else
        begin
            status_r <= status_nxt;
            irq_en_r <= irq_en_nxt;
            reinit_en_r <= reinit_en_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            irq_r <= irq_nxt;
            reinit_r <= reinit_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            arready_r <= arready_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign irq = irq_r;
    assign reinit_req = reinit_r;

    property p_sink_sets;
        @(posedge sys_clk) disable iff (!nrst)
        (ev.out_valid && !ev.sink_ready) |=> status_r[`RXE_BIT_SINK];
    endproperty
    a_sink_flag_set: assert property (p_sink_sets)
        else $error("sink flag not set");

    a_empty_flag_set: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (ev.link_running && |ev.buf_empty) |=> status_r[`RXE_BIT_EMPTY])
        else $error("empty flag not set");

    a_full_flag_set: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (ev.link_running && |ev.buf_full) |=> status_r[`RXE_BIT_FULL])
        else $error("full flag not set");

    a_lock_flag_set: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (ev.link_running && |ev.lock_lost) |=> status_r[`RXE_BIT_LOCK])
        else $error("lock flag not set");

    a_deskew_flag_set: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ev.deskew_over |=> status_r[`RXE_BIT_DESKEW])
        else $error("deskew flag not set");

    a_spare_stays_zero: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !status_r[`RXE_BIT_SPARE])
        else $error("spare flag set without cause");

    // Every readable word keeps its reserved bits clear
    a_reserved_read_zero: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        s_axi_rvalid |-> (s_axi_rdata & ~`RXE_FLAG_MASK) == 32'h0000_0000)
        else $error("reserved read bits nonzero");

    a_irq_follows: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ##1 irq == |($past(status_r) & $past(irq_en_r)))
        else $error("irq mismatch");

    a_reinit_follows: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ##1 reinit_req == |($past(status_r) & $past(reinit_en_r)))
        else $error("reinit mismatch");

    sequence s_sink_clear_write;
        wr_do && aw_addr_r == `RXE_OFS_STATUS && w_data_r[`RXE_BIT_SINK]
            && w_strb_r[0] && !set_vec[`RXE_BIT_SINK];
    endsequence

    a_sink_flag_clear: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        s_sink_clear_write |=> !status_r[`RXE_BIT_SINK])
        else $error("sink flag not cleared");
endmodule

// >>> verif/rxe_host.sv
`timescale 1ns/100ps
module rxe_host (
    input  wire logic        sys_clk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial
    begin
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
    end

    // Address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic pa;
        logic pw;
        pa = 1'h1;
        pw = 1'h1;
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        while (pa || pw)
        begin
            @(posedge sys_clk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            s_axi_awvalid <= pa;
            s_axi_wvalid  <= pw;
        end
        do @(posedge sys_clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    // Read data is judged by the bench monitor at the same edge
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        while (!s_axi_rvalid) @(posedge sys_clk);
        s_axi_rready <= 1'h0;
    endtask
endmodule

// >>> verif/rx_link_error_status_tb.sv
`timescale 1ns/100ps
`include "rxe_params.svh"
module rx_link_error_status_tb
    import rxe_pkg::*;
;
    localparam rxe_events_t EV_IDLE = 16'h0001;
    logic        sys_clk = 1'h0;
    logic        nrst = 1'h0;
    rxe_events_t ev = EV_IDLE;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, st, en_i, en_r;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, br;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, irq, reinit_req;
    logic [33:0] expq[$];
    logic [31:0] seed = 32'h0000_aa88;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cyc = 0;

    rxe_status uut (.sys_clk, .nrst, .ev, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .reinit_req);
    rxe_host hst (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

    always #50 sys_clk = ~sys_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string n, input logic [33:0] e, s);
        num_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic rdx(input logic [7:0] a, input logic [33:0] e);
        expq.push_back(e);
        hst.rd(a);
    endtask

    // One lane at random; sink ready only when the link is idle
    task automatic fire(input int k, input logic run);
        logic [3:0] ln;
        ln = 4'h1 << (rnd() % 4);
        @(posedge sys_clk);
        ev.link_running <= run;
        ev.sink_ready   <= !run;
        case (k)
            0: ev.buf_empty <= ln;
            1: ev.buf_full <= ln;
            2: ev.lock_lost <= ln;
            3: ev.deskew_over <= 1'h1;
            default: ev.out_valid <= 1'h1;
        endcase
        @(posedge sys_clk);
        ev <= EV_IDLE;
        repeat (2) @(posedge sys_clk);
    endtask

    always @(posedge sys_clk)
        if (s_axi_rvalid && s_axi_rready)
            chk("rdata", expq.pop_front(), {s_axi_rresp, s_axi_rdata});

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (20) @(posedge sys_clk);
        nrst <= 1'h1;
        rdx(`RXE_OFS_STATUS, 34'h0);
        rdx(`RXE_OFS_IRQ_EN, 34'h0);
        rdx(`RXE_OFS_REINIT, 34'h0);
        rdx(8'h10, {`RXE_RESP_SLVERR, 32'h0000_0000});
        hst.wr(8'h10, 32'hffff_ffff, br);
        chk("bresp", {32'h0000_0000, `RXE_RESP_SLVERR}, {32'h0000_0000, br});
        for (int p = 0; p < 10; p++)
        begin
            en_i = rnd();
            en_r = rnd();
            hst.wr(`RXE_OFS_IRQ_EN, en_i, br);
            chk("bresp_ok", {32'h0000_0000, `RXE_RESP_OKAY},
                {32'h0000_0000, br});
            hst.wr(`RXE_OFS_REINIT, en_r, br);
            rdx(`RXE_OFS_IRQ_EN, {2'h0, en_i & `RXE_FLAG_MASK});
            rdx(`RXE_OFS_REINIT, {2'h0, en_r & `RXE_FLAG_MASK});
            fire(p % 5, p >= 5);
            // Lane flags need a running link; deskew does not
            st = (p % 5 == 3 || p >= 5) ? 32'h1 << (7 - p % 5) : 32'h0;
            rdx(`RXE_OFS_STATUS, {2'h0, st});
            chk("irq", {33'h0_0000_0000, |(st & en_i)},
                {33'h0_0000_0000, irq});
            chk("reinit_req", {33'h0_0000_0000, |(st & en_r)},
                {33'h0_0000_0000, reinit_req});
            // Buffer faults leave the link unusable until a full reset
            if (st[`RXE_BIT_EMPTY] || st[`RXE_BIT_FULL])
            begin
                @(posedge sys_clk);
                nrst <= 1'h0;
                repeat (2) @(posedge sys_clk);
                nrst <= 1'h1;
                rdx(`RXE_OFS_STATUS, 34'h0);
                rdx(`RXE_OFS_IRQ_EN, 34'h0);
            end
            hst.wr(`RXE_OFS_STATUS, 32'hffff_ffff, br);
            rdx(`RXE_OFS_STATUS, 34'h0);
            chk("irq_clear", 34'h0, {33'h0_0000_0000, irq});
        end
        @(posedge sys_clk);
        end_of_test();
    end
endmodule
